// File: rtl/acs_defines.vh
// Functional notes
// - converter enabled only while converter_on set
// - writing go flag starts selected channel conversion
// - finish clears go, sets done, loads result
// - clearing go aborts, partial result loaded
// - unresolved bits copy last resolved bit
// - reset clears fields, powers off, aborts
// - conversion survives sleep only on rc clock
// - rc clock delays start one instruction cycle
// - completion in sleep with interrupt wakes
// - completion in sleep, interrupt off: power down
// - sleep on system clock aborts, powers down
// - codes 111 reference, 110 temperature channel
// - control register eight bits, go bit1, on bit0
// - done flag set on completed conversions only, software clears
// - codes 000-010 pins, 011-101 no channel
// - full conversion takes 9.5 bit periods
`ifndef ACS_DEFINES_VH
`define ACS_DEFINES_VH

// ---------------------------------------------------------------
// register map
// ---------------------------------------------------------------
`define ACS_ADDR_CONTROL 12'h000
`define ACS_ADDR_RESULT 12'h004
`define ACS_ADDR_STATUS 12'h008
`define ACS_CONTROL_RESET 8'h00
`define ACS_ON_BIT 0
`define ACS_GO_BIT 1
`define ACS_CHS_LSB 2
`define ACS_CLK_LSB 5
`define ACS_STAT_DONE_BIT 0
`define ACS_STAT_IE_BIT 1
`define ACS_STAT_PWR_BIT 2

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
// instruction cycle 250 ns at 4 ns clock
`define ACS_INSTR_NS 250
`define ACS_CLK_NS 4
// 250 ns / 4 ns, sized to the delay counter
`define ACS_INSTR_CYC 16'h003E
// rc clock half bit period, arbitrary plain default in system cycles
`define ACS_RC_HALF_CYC 16'h0100
// half-periods per conversion: 9.5 periods = 19 halves
`define ACS_HALVES 5'h13

`endif

// File: rtl/acs_sequencer.v
`timescale 1ns/1ps
`include "acs_defines.vh"

module acs_sequencer (
    // clock and reset
    input wire CLK_IN,
    input wire RST_IN,
    // ahb-lite slave
    input wire HSEL_IN,
    input wire [31:0] HADDR_IN,
    input wire [1:0] HTRANS_IN,
    input wire HWRITE_IN,
    input wire [2:0] HSIZE_IN,
    input wire [31:0] HWDATA_IN,
    input wire HREADY_IN,
    output wire [31:0] HRDATA_OUT,
    output wire HREADYOUT_OUT,
    output wire HRESP_OUT,
    // system
    input wire SLEEP_IN,
    output wire WAKE_OUT,
    // analog core
    input wire COMPARATOR_IN,
    output wire CORE_POWER_OUT,
    output wire SAMPLE_OUT,
    output wire [7:0] DAC_CODE_OUT,
    output wire [2:0] PIN_CHANNEL_OUT,
    output wire PIN_CHANNEL_VALID_OUT,
    output wire TEMP_SELECT_OUT,
    output wire REF_SELECT_OUT,
    output wire [2:0] CLOCK_SELECT_OUT
);

// ---------------------------------------------------------------
// states
// ---------------------------------------------------------------
localparam ST_IDLE = 4'b0001;
localparam ST_DELAY = 4'b0010;
localparam ST_CONV = 4'b0100;
localparam ST_DONE = 4'b1000;

reg [7:0] control_reg;
reg done_flag_reg;
reg int_enable_reg;
reg [7:0] result_reg;
reg [3:0] state_reg;
reg [15:0] div_cnt_reg;
reg [4:0] half_cnt_reg;
reg [7:0] sar_reg;
reg [7:0] trial_reg;
reg core_off_reg;
reg wake_reg;
reg [2:0] cmp_sync_reg;
reg cmp_reg;
reg [2:0] slp_sync_reg;
reg slp_reg;

reg wr_pend_reg;
reg rd_pend_reg;
reg [11:0] addr_reg;
reg [31:0] rdata_reg;

wire [2:0] clk_sel = control_reg[`ACS_CLK_LSB+2:`ACS_CLK_LSB];
wire [2:0] chs = control_reg[`ACS_CHS_LSB+2:`ACS_CHS_LSB];
wire conv_on = control_reg[`ACS_ON_BIT];
wire rc_sel = clk_sel[1] & clk_sel[0];

// ---------------------------------------------------------------
// clock select decode
// ---------------------------------------------------------------
reg [15:0] half_len;
always @* begin
    case (clk_sel)
        3'b000: half_len = 16'h0001;
        3'b001: half_len = 16'h0004;
        3'b010: half_len = 16'h0010;
        3'b100: half_len = 16'h0002;
        3'b101: half_len = 16'h0008;
        3'b110: half_len = 16'h0020;
        default: half_len = `ACS_RC_HALF_CYC;
    endcase
end

// ---------------------------------------------------------------
// input synchronisers
// ---------------------------------------------------------------
always @(posedge CLK_IN) begin
    if (RST_IN) begin
        cmp_sync_reg <= 3'b000;
        cmp_reg <= 1'b0;
        slp_sync_reg <= 3'b000;
        slp_reg <= 1'b0;
    end else begin
        cmp_sync_reg <= {cmp_sync_reg[1:0], COMPARATOR_IN};
        slp_sync_reg <= {slp_sync_reg[1:0], SLEEP_IN};
        // a level counts once the second and third stages agree
        if (cmp_sync_reg[2] == cmp_sync_reg[1]) begin
            cmp_reg <= cmp_sync_reg[2];
        end
        if (slp_sync_reg[2] == slp_sync_reg[1]) begin
            slp_reg <= slp_sync_reg[2];
        end
    end
end

// ---------------------------------------------------------------
// bus slave
// ---------------------------------------------------------------
// unmapped offsets read zero and ignore writes
wire take = HSEL_IN & HREADY_IN & HTRANS_IN[1];
wire wr_ctrl = wr_pend_reg & (addr_reg == `ACS_ADDR_CONTROL);
wire wr_stat = wr_pend_reg & (addr_reg == `ACS_ADDR_STATUS);
wire [7:0] wdat = HWDATA_IN[7:0];

always @(posedge CLK_IN) begin
    if (RST_IN) begin
        wr_pend_reg <= 1'b0;
        rd_pend_reg <= 1'b0;
        addr_reg <= 12'h000;
    end else begin
        wr_pend_reg <= take & HWRITE_IN;
        rd_pend_reg <= take & ~HWRITE_IN;
        if (take) begin
            addr_reg <= HADDR_IN[11:0];
        end
    end
end

// read data latched in the address phase so the data phase has no wait
always @(posedge CLK_IN) begin
    if (RST_IN) begin
        rdata_reg <= 32'h0000_0000;
    end else if (take & ~HWRITE_IN) begin
        case (HADDR_IN[11:0])
            `ACS_ADDR_CONTROL: rdata_reg <= {24'h00_0000, control_reg};
            `ACS_ADDR_RESULT: rdata_reg <= {24'h00_0000, result_reg};
            `ACS_ADDR_STATUS: rdata_reg <= {29'h0000_0000, core_off_reg,
                                            int_enable_reg, done_flag_reg};
            default: rdata_reg <= 32'h0000_0000;
        endcase
    end
end

assign HRDATA_OUT = rdata_reg;
assign HREADYOUT_OUT = 1'b1;
assign HRESP_OUT = 1'b0;

// ---------------------------------------------------------------
// conversion sequencer
// ---------------------------------------------------------------
wire go_write = wr_ctrl & wdat[`ACS_GO_BIT];
wire abort_sw = wr_ctrl & ~wdat[`ACS_GO_BIT] & (state_reg != ST_IDLE);
wire abort_sleep = slp_reg & ~rc_sel & (state_reg != ST_IDLE);
wire abort_off = ~conv_on & (state_reg != ST_IDLE);
wire half_tick = (div_cnt_reg == 16'h0001);
// bit 7..0 resolved on odd half counts 3,5,..,17; done after 19 halves
wire resolve = half_tick & half_cnt_reg[0] & (half_cnt_reg >= 5'h03)
    & (half_cnt_reg <= 5'h11);
// the nineteenth half period ends the conversion; results load one cycle later
wire finish = half_tick & (half_cnt_reg == (`ACS_HALVES - 5'h01));

// ---------------------------------------------------------------
// partial result
// ---------------------------------------------------------------
// unresolved low bits copy the last resolved bit; with nothing
// resolved yet the whole word stays zero
wire [7:0] partial;
assign partial[7] = sar_reg[7];
genvar g;
generate
    for (g = 0; g < 7; g = g + 1) begin : g_fill
        // bit g is still open while the trial marker sits at or above it
        assign partial[g] = (|trial_reg[7:g]) ? partial[g+1] : sar_reg[g];
    end
endgenerate

always @(posedge CLK_IN) begin
    if (RST_IN) begin
        control_reg <= `ACS_CONTROL_RESET;
        state_reg <= ST_IDLE;
        div_cnt_reg <= 16'h0000;
        half_cnt_reg <= 5'h00;
        sar_reg <= 8'h00;
        trial_reg <= 8'h00;
        result_reg <= 8'h00;
        done_flag_reg <= 1'b0;
        int_enable_reg <= 1'b0;
        core_off_reg <= 1'b0;
        wake_reg <= 1'b0;
    end else begin
        wake_reg <= 1'b0;
        if (wr_stat) begin
            int_enable_reg <= wdat[`ACS_STAT_IE_BIT];
        end
        if (wr_ctrl) begin
            control_reg <= wdat;
            if (wdat[`ACS_ON_BIT]) begin
                core_off_reg <= 1'b0;
            end
        end
        // set wins over software clear
        if (wr_stat & wdat[`ACS_STAT_DONE_BIT]) begin
            done_flag_reg <= 1'b0;
        end
        case (state_reg)
            ST_IDLE: begin
                if (go_write & conv_on & wdat[`ACS_ON_BIT]) begin
                    sar_reg <= 8'h00;
                    trial_reg <= 8'h80;
                    half_cnt_reg <= 5'h00;
                    core_off_reg <= 1'b0;
                    if (rc_sel) begin
                        div_cnt_reg <= `ACS_INSTR_CYC;
                        state_reg <= ST_DELAY;
                    end else begin
                        div_cnt_reg <= half_len;
                        state_reg <= ST_CONV;
                    end
                end else if (go_write) begin
                    control_reg[`ACS_GO_BIT] <= 1'b0;
                end
            end
            ST_DELAY: begin
                control_reg[`ACS_GO_BIT] <= 1'b1;
                div_cnt_reg <= div_cnt_reg - 16'h0001;
                if (div_cnt_reg == 16'h0001) begin
                    div_cnt_reg <= half_len;
                    state_reg <= ST_CONV;
                end
            end
            ST_CONV: begin
                if (!wr_ctrl) begin
                    control_reg[`ACS_GO_BIT] <= 1'b1;
                end
                div_cnt_reg <= half_tick ? half_len : div_cnt_reg - 16'h0001;
                if (half_tick) begin
                    half_cnt_reg <= half_cnt_reg + 5'h01;
                end
                if (resolve) begin
                    sar_reg <= cmp_reg ? (sar_reg | trial_reg) : sar_reg;
                    trial_reg <= {1'b0, trial_reg[7:1]};
                end
                if (finish) begin
                    state_reg <= ST_DONE;
                end
            end
            default: begin
                control_reg[`ACS_GO_BIT] <= 1'b0;
                result_reg <= sar_reg;
                done_flag_reg <= 1'b1;
                if (slp_reg) begin
                    if (int_enable_reg) begin
                        wake_reg <= 1'b1;
                    end else begin
                        core_off_reg <= 1'b1;
                    end
                end
                state_reg <= ST_IDLE;
            end
        endcase
        // an abort from any source overrides the step taken above,
        // and go must never stay set once the sequencer is idle
        if (abort_sw | abort_sleep | abort_off) begin
            state_reg <= ST_IDLE;
            result_reg <= partial;
            control_reg[`ACS_GO_BIT] <= 1'b0;
            if (abort_sleep) begin
                core_off_reg <= 1'b1;
            end
        end else if (slp_reg & ~rc_sel & ~wr_ctrl) begin
            // an idle converter asleep on a system divider stays powered down
            core_off_reg <= 1'b1;
        end
    end
end

// ---------------------------------------------------------------
// trial code register
// ---------------------------------------------------------------
// the decision loop through the core and the synchroniser is about
// six cycles, so dividers /2 and /4 resolve on a stale decision
reg [7:0] dac_code_reg;
always @(posedge CLK_IN) begin
    if (RST_IN) begin
        dac_code_reg <= 8'h00;
    end else begin
        dac_code_reg <= sar_reg | trial_reg;
    end
end

// ---------------------------------------------------------------
// analog core drive
// ---------------------------------------------------------------
// the on bit keeps reading set while the core itself is powered down
assign CORE_POWER_OUT = conv_on & ~core_off_reg;
assign SAMPLE_OUT = (state_reg == ST_IDLE) | (state_reg == ST_DELAY);
assign DAC_CODE_OUT = dac_code_reg;
assign WAKE_OUT = wake_reg;
assign CLOCK_SELECT_OUT = clk_sel;
assign PIN_CHANNEL_OUT = chs;
assign PIN_CHANNEL_VALID_OUT = (chs <= 3'b010);
assign TEMP_SELECT_OUT = (chs == 3'b110);
assign REF_SELECT_OUT = (chs == 3'b111);

endmodule

// File: tb/acs_core_model.sv
`timescale 1ns/1ps
module acs_core_model (
    input wire clk_in,
    input wire power_in,
    input wire [7:0] dac_code_in,
    input wire [7:0] level_in,
    output reg comparator_out
);
    initial comparator_out = 1'b0;
    // an unpowered core gives no valid decision, so the line keeps toggling
    always @(posedge clk_in) begin
        comparator_out <= power_in ? (dac_code_in <= level_in) : ~comparator_out;
    end
endmodule

// File: tb/acs_properties.sv
`timescale 1ns/1ps
module acs_properties (
    input wire CLK_IN, input wire RST_IN, input wire SLEEP_IN, input wire WAKE_OUT,
    input wire CORE_POWER_OUT, input wire SAMPLE_OUT, input wire [2:0] PIN_CHANNEL_OUT,
    input wire PIN_CHANNEL_VALID_OUT, input wire TEMP_SELECT_OUT, input wire REF_SELECT_OUT,
    input wire [2:0] CLOCK_SELECT_OUT
);
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (RST_IN);
    // cycles of the running conversion: 19 halves of 16 at divider /32, plus the done cycle
    logic [9:0] low_cnt;
    always @(posedge CLK_IN) begin
        low_cnt <= (RST_IN || SAMPLE_OUT) ? 10'h000 : low_cnt + 10'h001;
    end
    ref_route_a: assert property (REF_SELECT_OUT == (PIN_CHANNEL_OUT == 3'b111))
        else $error("ref route");
    temp_route_a: assert property (TEMP_SELECT_OUT == (PIN_CHANNEL_OUT == 3'b110))
        else $error("temp route");
    pin_route_a: assert property (PIN_CHANNEL_VALID_OUT == (PIN_CHANNEL_OUT < 3'b011))
        else $error("pin valid");
    reset_off_a: assert property (disable iff (1'b0)
        RST_IN |=> !CORE_POWER_OUT && SAMPLE_OUT && !WAKE_OUT) else $error("reset state");
    start_power_a: assert property ($fell(SAMPLE_OUT) |-> CORE_POWER_OUT)
        else $error("start unpowered");
    wake_pulse_a: assert property (WAKE_OUT |=> !WAKE_OUT)
        else $error("wake too long");
    sleep_abort_a: assert property (SLEEP_IN && CLOCK_SELECT_OUT[1:0] != 2'b11 && !SAMPLE_OUT
        |-> ##[1:8] SAMPLE_OUT && !CORE_POWER_OUT) else $error("no sleep abort");
    conv_len_a: assert property (CLOCK_SELECT_OUT == 3'b010 |-> low_cnt <= 10'h131)
        else $error("conversion too long");
    wake_c: cover property (WAKE_OUT);
    end_c: cover property ($rose(SAMPLE_OUT) && CLOCK_SELECT_OUT == 3'b010);
    sleep_c: cover property (SLEEP_IN && !SAMPLE_OUT);
endmodule
bind acs_sequencer acs_properties i_acs_properties (.*);

// File: tb/tb_top.sv
`timescale 1ns/1ps
`include "acs_defines.vh"
module tb_top;
    localparam logic [11:0] ctl = `ACS_ADDR_CONTROL;
    localparam logic [11:0] res = `ACS_ADDR_RESULT;
    localparam logic [11:0] sta = `ACS_ADDR_STATUS;
    logic clk = 1'b0, rst = 1'b1, slp = 1'b0, hw = 1'b0;
    logic [1:0] ht = 2'b00;
    logic [11:0] ha = 12'h000;
    logic [31:0] hd = 32'h0000_0000;
    logic [7:0] lvl = 8'hA5;
    wire [31:0] hr;
    wire rdy, rsp, wake, pwr, smp, pv, ts, rs, cmpi;
    wire [7:0] dac;
    wire [2:0] pch, cs;
    int num_errors = 0, n_compared = 0, cyc = 0, n;
    always #2 clk = ~clk;
    acs_sequencer i_acs_sequencer (.CLK_IN(clk), .RST_IN(rst), .HSEL_IN(1'b1),
        .HADDR_IN({20'h0_0000, ha}), .HTRANS_IN(ht), .HWRITE_IN(hw), .HSIZE_IN(3'b010),
        .HWDATA_IN(hd), .HREADY_IN(rdy), .HRDATA_OUT(hr), .HREADYOUT_OUT(rdy),
        .HRESP_OUT(rsp), .SLEEP_IN(slp), .WAKE_OUT(wake), .COMPARATOR_IN(cmpi),
        .CORE_POWER_OUT(pwr), .SAMPLE_OUT(smp), .DAC_CODE_OUT(dac), .PIN_CHANNEL_OUT(pch),
        .PIN_CHANNEL_VALID_OUT(pv), .TEMP_SELECT_OUT(ts), .REF_SELECT_OUT(rs),
        .CLOCK_SELECT_OUT(cs));
    acs_core_model i_acs_core_model (.clk_in(clk), .power_in(pwr), .dac_code_in(dac),
        .level_in(lvl), .comparator_out(cmpi));
    task automatic cmp(input logic [31:0] g, input logic [31:0] e);
        n_compared++;
        if (g !== e) begin
            num_errors++;
            $display("ERROR %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic bus(input logic w, input logic [11:0] a, input logic [7:0] d,
        output logic [31:0] r);
        ht <= 2'b10;
        ha <= a;
        hw <= w;
        @(posedge clk);
        while (rdy !== 1'b1) @(posedge clk);
        ht <= 2'b00;
        hd <= {24'h00_0000, d};
        @(posedge clk);
        while (rdy !== 1'b1) @(posedge clk);
        r = hr;
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        logic [31:0] r;
        bus(1'b1, a, d, r);
    endtask
    task automatic chk(input logic [11:0] a, input logic [7:0] e);
        logic [31:0] r;
        bus(1'b0, a, 8'h00, r);
        cmp(r, {24'h00_0000, e});
    endtask
    task automatic poll(input int k);
        logic [31:0] r;
        r = 32'h0000_0002;
        while (k > 0 && r[1] !== 1'b0) begin
            bus(1'b0, ctl, 8'h00, r);
            k--;
        end
        cmp(r[1], 1'b0);
    endtask
    task automatic test_done;
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            num_errors++;
            test_done;
        end
    end
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk(ctl, 8'h00);
        chk(sta, 8'h00);
        wr(12'h010, 8'hFF);
        chk(12'h010, 8'h00);
        cmp(rsp, 1'b0);
        wr(ctl, 8'h03);
        chk(ctl, 8'h01);
        for (int c = 0; c < 8; c++) begin
            wr(ctl, {c[2:0], c[2:0], 2'b01});
            chk(ctl, {c[2:0], c[2:0], 2'b01});
            @(posedge clk);
            cmp({pch, pv, ts, rs}, {c[2:0], c < 3, c == 6, c == 7});
            cmp({cs, pwr}, {c[2:0], 1'b1});
        end
        wr(ctl, 8'h00);
        @(posedge clk);
        cmp(pwr, 1'b0);
        $display("test registers end");
        wr(ctl, 8'h41);
        repeat (8) @(posedge clk);
        wr(ctl, 8'h43);
        repeat (280) @(posedge clk);
        chk(ctl, 8'h43);
        poll(40);
        chk(res, 8'hA5);
        chk(sta, 8'h01);
        wr(sta, 8'h01);
        chk(sta, 8'h00);
        lvl <= 8'hF0;
        wr(ctl, 8'h43);
        repeat (100) @(posedge clk);
        wr(ctl, 8'h41);
        repeat (4) @(posedge clk);
        chk(res, 8'hFF);
        chk(sta, 8'h00);
        $display("test conversion end");
        wr(ctl, 8'h43);
        repeat (20) @(posedge clk);
        slp <= 1'b1;
        repeat (20) @(posedge clk);
        chk(ctl, 8'h41);
        chk(sta, 8'h04);
        slp <= 1'b0;
        repeat (6) @(posedge clk);
        wr(ctl, 8'h41);
        chk(sta, 8'h00);
        lvl <= 8'hA5;
        wr(sta, 8'h02);
        wr(ctl, 8'h61);
        wr(ctl, 8'h63);
        repeat (20) @(posedge clk);
        cmp(smp, 1'b1);
        slp <= 1'b1;
        n = 0;
        while (wake !== 1'b1 && n < 6000) begin
            @(posedge clk);
            n++;
        end
        cmp(wake, 1'b1);
        slp <= 1'b0;
        chk(res, 8'hA5);
        chk(sta, 8'h03);
        wr(sta, 8'h01);
        wr(ctl, 8'h63);
        repeat (20) @(posedge clk);
        slp <= 1'b1;
        repeat (5200) @(posedge clk);
        chk(ctl, 8'h61);
        chk(sta, 8'h05);
        cmp(pwr, 1'b0);
        slp <= 1'b0;
        $display("test sleep end");
        repeat (6) @(posedge clk);
        wr(ctl, 8'h41);
        wr(ctl, 8'h43);
        repeat (50) @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk(ctl, 8'h00);
        chk(res, 8'h00);
        chk(sta, 8'h00);
        cmp({pwr, smp}, 2'b01);
        $display("test reset end");
        test_done;
    end
endmodule
